//--- hdl/idblk_defines.svh
// idblk_defines.svh: word addresses, fixed values and field positions of the
// parameter block.
// assumes: included by bare name from the design file.
`ifndef IDBLK_DEFINES_SVH
`define IDBLK_DEFINES_SVH

`define ID_WORDS 9'h100
`define ID_W_CONFIG 8'h00
`define ID_W_CYL 8'h01
`define ID_W_HEADS 8'h03
`define ID_W_SPT 8'h06
`define ID_W_TOT_HI 8'h07
`define ID_W_TOT_LO 8'h08
`define ID_W_SER_FIRST 8'h0a
`define ID_W_SER_LAST 8'h13
`define ID_W_ECC 8'h16
`define ID_W_FW_FIRST 8'h17
`define ID_W_FW_LAST 8'h1a
`define ID_W_MOD_FIRST 8'h1b
`define ID_W_MOD_LAST 8'h2e
`define ID_W_MULT_MAX 8'h2f
`define ID_W_CAPS 8'h31
`define ID_W_PIO_MODE 8'h33
`define ID_W_VALID 8'h35
`define ID_W_CUR_CYL 8'h36
`define ID_W_CUR_HEADS 8'h37
`define ID_W_CUR_SPT 8'h38
`define ID_W_CAP_LO 8'h39
`define ID_W_CAP_HI 8'h3a
`define ID_W_MULT_SET 8'h3b
`define ID_W_LBA_LO 8'h3c
`define ID_W_LBA_HI 8'h3d
`define ID_W_DMA 8'h3f
`define ID_W_ADV_PIO 8'h40
`define ID_W_DMA_MIN 8'h41
`define ID_W_DMA_REC 8'h42
`define ID_W_PIO_MIN 8'h43
`define ID_W_PIO_IORDY 8'h44
`define ID_W_SECURITY 8'h80
`define ID_ECC_COUNT 16'h0004
`define ID_SPACE 8'h20
`define ID_MULT_VALID_BIT 8
`define ID_GEOM_VALID_BIT 0
`define ID_SER_BYTES 20
`define ID_FW_BYTES 8
`define ID_MOD_BYTES 40
`define ID_FIFO_DEPTH 8

`endif

//--- hdl/idblk_pkg.sv
// idblk_pkg.sv: types shared by the parameter block design.
// assumes: idblk_defines.svh on the include path.
package idblk_pkg;
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_FILL
  } gen_state_e;

  typedef struct packed {
    gen_state_e state;
    logic [8:0] word_index;
    logic busy;
  } gen_regs_s;
endpackage

//--- hdl/identify_parameter_block.sv
// identify_parameter_block.sv: generator of the 256-word identify block
// feeding an output fifo, plus the fifo itself.
// assumes: one synchronous clock, geometry and strings stable while a
// block is produced, the reader takes words by valid/ready.
`timescale 1ns/100ps
`default_nettype none
`include "idblk_defines.svh"

module idblk_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd_ptr;
    logic [AW-1:0] wr_ptr;
    logic [CW-1:0] count;
    logic [WIDTH-1:0] head;
    logic head_valid;
  } fifo_regs_s;

  fifo_regs_s cur;
  fifo_regs_s next_cur;
  logic push;
  logic pop;
  logic load_head;

  // ---------------------------------------------
  // storage behind a registered head word
  // ---------------------------------------------
  always_comb begin
    next_cur = cur;
    push = in_valid_i && (cur.count != CW'(DEPTH));
    load_head = !cur.head_valid || out_ready_i;
    pop = load_head && (cur.count != '0);
    if (push) begin
      next_cur.mem[cur.wr_ptr] = in_data_i;
      next_cur.wr_ptr = (cur.wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(cur.wr_ptr + 1'b1);
    end
    if (load_head) begin
      next_cur.head_valid = (cur.count != '0);
      if (pop) begin
        next_cur.head = cur.mem[cur.rd_ptr];
        next_cur.rd_ptr = (cur.rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(cur.rd_ptr + 1'b1);
      end
    end
    next_cur.count = CW'(cur.count + CW'(push) - CW'(pop));
    if (!rstn_i) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    cur <= next_cur;
  end

  assign in_ready_o = (cur.count != CW'(DEPTH));
  assign out_data_o = cur.head;
  assign out_valid_o = cur.head_valid;
endmodule

module identify_parameter_block #(
  parameter logic [15:0] CLASS_SIGNATURE = 16'h8123, // arbitrary value
  parameter logic [15:0] IDE_CONFIG = 16'h0040,
  parameter int FIFO_DEPTH = `ID_FIFO_DEPTH
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic card_mode_i,
  input wire logic [15:0] cylinders_i,
  input wire logic [7:0] heads_i,
  input wire logic [15:0] sectors_per_track_i,
  input wire logic [31:0] total_sectors_i,
  input wire logic [15:0] cur_cylinders_i,
  input wire logic [15:0] cur_heads_i,
  input wire logic [15:0] cur_sectors_per_track_i,
  input wire logic [31:0] cur_capacity_i,
  input wire logic [31:0] lba_sectors_i,
  input wire logic [7:0] multiple_max_i,
  input wire logic [7:0] multiple_setting_i,
  input wire logic [15:0] capabilities_i,
  input wire logic [7:0] pio_mode_i,
  input wire logic [15:0] validity_i,
  input wire logic [15:0] dma_modes_i,
  input wire logic [7:0] adv_pio_i,
  input wire logic [15:0] dma_min_cycle_i,
  input wire logic [15:0] dma_rec_cycle_i,
  input wire logic [15:0] pio_min_cycle_i,
  input wire logic [15:0] pio_iordy_cycle_i,
  input wire logic [15:0] security_i,
  input wire logic [8*`ID_SER_BYTES-1:0] serial_i,
  input wire logic [8*`ID_FW_BYTES-1:0] firmware_i,
  input wire logic [8*`ID_MOD_BYTES-1:0] model_i,
  output logic busy_o,
  output logic [15:0] data_o,
  output logic data_valid_o,
  input wire logic data_ready_i
);
  idblk_pkg::gen_regs_s cur;
  idblk_pkg::gen_regs_s next_cur;
  logic [15:0] word;
  logic fifo_ready;
  logic push;
  logic [7:0] addr;
  logic [7:0] off;
  logic [7:0] hi_byte;
  logic [7:0] lo_byte;

  // string byte n counted from the first character; characters sit msb first
  function automatic logic [7:0] str_byte(input logic [8*`ID_MOD_BYTES-1:0] s,
                                          input int len, input int n);
    logic [7:0] b;
    b = s[8*(len-1-n) +: 8];
    return b;
  endfunction

  // ---------------------------------------------
  // word content by address
  // ---------------------------------------------
  always_comb begin
    addr = cur.word_index[7:0];
    off = 8'h00;
    hi_byte = 8'h00;
    lo_byte = 8'h00;
    word = 16'h0000;
    case (addr)
      `ID_W_CONFIG: word = card_mode_i ? CLASS_SIGNATURE : IDE_CONFIG;
      `ID_W_CYL: word = cylinders_i;
      `ID_W_HEADS: word = {8'h00, heads_i};
      `ID_W_SPT: word = sectors_per_track_i;
      `ID_W_TOT_HI: word = total_sectors_i[31:16];
      `ID_W_TOT_LO: word = total_sectors_i[15:0];
      `ID_W_ECC: word = `ID_ECC_COUNT;
      `ID_W_MULT_MAX: word = {8'h00, multiple_max_i};
      `ID_W_CAPS: word = {capabilities_i[15:8], 8'h00};
      `ID_W_PIO_MODE: word = {pio_mode_i, 8'h00};
      `ID_W_VALID: word = validity_i | 16'h0001;
      `ID_W_CUR_CYL: word = cur_cylinders_i;
      `ID_W_CUR_HEADS: word = cur_heads_i;
      `ID_W_CUR_SPT: word = cur_sectors_per_track_i;
      `ID_W_CAP_LO: word = cur_capacity_i[15:0];
      `ID_W_CAP_HI: word = cur_capacity_i[31:16];
      `ID_W_MULT_SET: word = {8'h01, multiple_setting_i};
      `ID_W_LBA_LO: word = lba_sectors_i[15:0];
      `ID_W_LBA_HI: word = lba_sectors_i[31:16];
      `ID_W_DMA: word = card_mode_i ? 16'h0000 : dma_modes_i;
      `ID_W_ADV_PIO: word = {8'h00, adv_pio_i};
      `ID_W_DMA_MIN: word = card_mode_i ? 16'h0000 : dma_min_cycle_i;
      `ID_W_DMA_REC: word = card_mode_i ? 16'h0000 : dma_rec_cycle_i;
      `ID_W_PIO_MIN: word = pio_min_cycle_i;
      `ID_W_PIO_IORDY: word = pio_iordy_cycle_i;
      `ID_W_SECURITY: word = security_i;
      default: begin
        if (addr >= `ID_W_SER_FIRST && addr <= `ID_W_SER_LAST) begin
          off = 8'((addr - `ID_W_SER_FIRST) << 1);
          hi_byte = str_byte({{(8*(`ID_MOD_BYTES-`ID_SER_BYTES)){1'b0}}, serial_i},
                             `ID_SER_BYTES, int'(off));
          lo_byte = str_byte({{(8*(`ID_MOD_BYTES-`ID_SER_BYTES)){1'b0}}, serial_i},
                             `ID_SER_BYTES, int'(off) + 1);
          word = {hi_byte, lo_byte};
        end else if (addr >= `ID_W_FW_FIRST && addr <= `ID_W_FW_LAST) begin
          off = 8'((addr - `ID_W_FW_FIRST) << 1);
          hi_byte = str_byte({{(8*(`ID_MOD_BYTES-`ID_FW_BYTES)){1'b0}}, firmware_i},
                             `ID_FW_BYTES, int'(off));
          lo_byte = str_byte({{(8*(`ID_MOD_BYTES-`ID_FW_BYTES)){1'b0}}, firmware_i},
                             `ID_FW_BYTES, int'(off) + 1);
          word = {hi_byte, lo_byte};
        end else if (addr >= `ID_W_MOD_FIRST && addr <= `ID_W_MOD_LAST) begin
          off = 8'((addr - `ID_W_MOD_FIRST) << 1);
          hi_byte = str_byte(model_i, `ID_MOD_BYTES, int'(off));
          lo_byte = str_byte(model_i, `ID_MOD_BYTES, int'(off) + 1);
          word = {hi_byte, lo_byte};
        end
      end
    endcase
  end

  // ---------------------------------------------
  // word sequencer
  // ---------------------------------------------
  always_comb begin
    next_cur = cur;
    push = 1'b0;
    case (cur.state)
      idblk_pkg::ST_IDLE: begin
        if (start_i) begin
          next_cur.state = idblk_pkg::ST_FILL;
          next_cur.word_index = '0;
        end
      end
      idblk_pkg::ST_FILL: begin
        push = 1'b1;
        if (fifo_ready) begin
          next_cur.word_index = 9'(cur.word_index + 1'b1);
          if (cur.word_index == 9'(`ID_WORDS - 1)) begin
            next_cur.state = idblk_pkg::ST_IDLE;
          end
        end
      end
      default: next_cur.state = idblk_pkg::ST_IDLE;
    endcase
    next_cur.busy = (next_cur.state == idblk_pkg::ST_FILL) || push;
    if (!rstn_i) begin
      next_cur.state = idblk_pkg::ST_IDLE;
      next_cur.word_index = '0;
      next_cur.busy = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    cur <= next_cur;
  end

  assign busy_o = cur.busy;

  // words leave through the fifo, paced by the reader like sector data
  idblk_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .in_data_i(word),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .out_data_o(data_o),
    .out_valid_o(data_valid_o),
    .out_ready_i(data_ready_i)
  );

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  property p_ecc_word;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && fifo_ready && cur.word_index == 9'h016) |-> word == 16'h0004;
  endproperty
  a_ecc_word: assert property (p_ecc_word) else $error("ecc word wrong");

  property p_mult_valid;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h03b) |-> word[8] && word[15:9] == 7'h00;
  endproperty
  a_mult_valid: assert property (p_mult_valid) else $error("mult valid bit");

  property p_geom_valid;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h035) |-> word[0];
  endproperty
  a_geom_valid: assert property (p_geom_valid) else $error("validity bit 0");

  property p_card_dma_zero;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && card_mode_i && (cur.word_index == 9'h03f || cur.word_index == 9'h041
       || cur.word_index == 9'h042)) |-> word == 16'h0000;
  endproperty
  a_card_dma_zero: assert property (p_card_dma_zero) else $error("dma nonzero");

  property p_reserved_zero;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && (cur.word_index >= 9'h045) && (cur.word_index != 9'h080)) |-> word == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved nonzero");

  property p_ascending;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && fifo_ready && cur.word_index != 9'h0ff) |=> cur.word_index == $past(cur.word_index) + 9'h001;
  endproperty
  a_ascending: assert property (p_ascending) else $error("order broken");

  property p_total_order;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && fifo_ready && cur.word_index == 9'h007) |-> word == total_sectors_i[31:16];
  endproperty
  a_total_order: assert property (p_total_order) else $error("total msw");

  property p_cap_order;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h039) |-> word == cur_capacity_i[15:0];
  endproperty
  a_cap_order: assert property (p_cap_order) else $error("capacity lsw");

  property p_config_word;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && card_mode_i && cur.word_index == 9'h000) |-> word == CLASS_SIGNATURE;
  endproperty
  a_config_word: assert property (p_config_word) else $error("signature word");

  property p_heads_upper;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h003) |-> word[15:8] == 8'h00;
  endproperty
  a_heads_upper: assert property (p_heads_upper) else $error("heads upper byte");

  property p_pio_low;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h033) |-> word[7:0] == 8'h00;
  endproperty
  a_pio_low: assert property (p_pio_low) else $error("pio mode low byte");

  property p_adv_pio_upper;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h040) |-> word[15:8] == 8'h00;
  endproperty
  a_adv_pio_upper: assert property (p_adv_pio_upper) else $error("adv pio upper");

  property p_serial_first;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h00a) |-> word == serial_i[159:144];
  endproperty
  a_serial_first: assert property (p_serial_first) else $error("serial word");

  property p_fw_first;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h017) |-> word == firmware_i[63:48];
  endproperty
  a_fw_first: assert property (p_fw_first) else $error("firmware word");

  property p_model_first;
    @(posedge clock_i) disable iff (!rstn_i)
      (push && cur.word_index == 9'h01b) |-> word == model_i[319:304];
  endproperty
  a_model_first: assert property (p_model_first) else $error("model word");

  property p_valid_hold;
    @(posedge clock_i) disable iff (!rstn_i)
      (data_valid_o && !data_ready_i) |=> data_valid_o && $stable(data_o);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("word dropped");

  property p_start_word0;
    @(posedge clock_i) disable iff (!rstn_i)
      (cur.state == idblk_pkg::ST_IDLE && start_i) |=> busy_o && cur.word_index == 9'h000;
  endproperty
  a_start_word0: assert property (p_start_word0) else $error("start word");
endmodule

`default_nettype wire

//--- tb/idblk_reader.sv
// idblk_reader.sv: host side reader model that takes words off the block.
// assumes: the bench clock; the bench picks a pacing mode per block and may switch it mid-block.
`timescale 1ns/100ps
`default_nettype none

module idblk_reader (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  // ----------------------------------------
  // ready pacing: prompt, random, stalled
  // ----------------------------------------
  initial ready_o = 1'b0;
  always @(posedge clock_i) begin
    #2;
    if (rstn_i !== 1'b1) begin
      ready_o = 1'b0;
    end else begin
      case (mode_i)
        2'd0: ready_o = 1'b1;
        2'd1: ready_o = 1'($urandom_range(1, 0));
        default: ready_o = 1'b0;
      endcase
    end
  end
endmodule

`default_nettype wire

//--- tb/tb_identify_parameter_block.sv
// tb_identify_parameter_block.sv: self-checking bench for the block.
// assumes: idblk_reader model on the reader side, one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module tb_identify_parameter_block;
  localparam logic [15:0] SIG = 16'h5a3c; // arbitrary value
  localparam logic [15:0] IDE = 16'h0c41; // arbitrary value
  logic clock_i, rstn_i, start_i, card_mode_i, busy_o, data_valid_o, data_ready_i;
  logic [15:0] cylinders_i, sectors_per_track_i, cur_cylinders_i, cur_heads_i;
  logic [15:0] cur_sectors_per_track_i, capabilities_i, validity_i, dma_modes_i;
  logic [15:0] dma_min_cycle_i, dma_rec_cycle_i, pio_min_cycle_i, pio_iordy_cycle_i;
  logic [15:0] security_i, data_o;
  logic [7:0] heads_i, multiple_max_i, multiple_setting_i, pio_mode_i, adv_pio_i;
  logic [31:0] total_sectors_i, cur_capacity_i, lba_sectors_i;
  logic [159:0] serial_i;
  logic [63:0] firmware_i;
  logic [319:0] model_i;
  logic [1:0] pace;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int n_tests = 0;
  int cycles = 0;

  identify_parameter_block #(.CLASS_SIGNATURE(SIG), .IDE_CONFIG(IDE), .FIFO_DEPTH(8)) dut (
    .clock_i(clock_i), .rstn_i(rstn_i), .start_i(start_i), .card_mode_i(card_mode_i),
    .cylinders_i(cylinders_i), .heads_i(heads_i), .sectors_per_track_i(sectors_per_track_i),
    .total_sectors_i(total_sectors_i), .cur_cylinders_i(cur_cylinders_i),
    .cur_heads_i(cur_heads_i), .cur_sectors_per_track_i(cur_sectors_per_track_i),
    .cur_capacity_i(cur_capacity_i), .lba_sectors_i(lba_sectors_i),
    .multiple_max_i(multiple_max_i), .multiple_setting_i(multiple_setting_i),
    .capabilities_i(capabilities_i), .pio_mode_i(pio_mode_i), .validity_i(validity_i),
    .dma_modes_i(dma_modes_i), .adv_pio_i(adv_pio_i), .dma_min_cycle_i(dma_min_cycle_i),
    .dma_rec_cycle_i(dma_rec_cycle_i), .pio_min_cycle_i(pio_min_cycle_i),
    .pio_iordy_cycle_i(pio_iordy_cycle_i), .security_i(security_i), .serial_i(serial_i),
    .firmware_i(firmware_i), .model_i(model_i), .busy_o(busy_o), .data_o(data_o),
    .data_valid_o(data_valid_o), .data_ready_i(data_ready_i));

  idblk_reader reader (.clock_i(clock_i), .rstn_i(rstn_i), .mode_i(pace),
    .ready_o(data_ready_i));

  // ----------------------------------------
  // clock, timeout, checking
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // monitor: one note per accepted word
  // ----------------------------------------
  always @(posedge clock_i) begin
    if (rstn_i === 1'b1 && data_valid_o === 1'b1 && data_ready_i === 1'b1) begin
      if (exp_q.size() == 0) check("extra word", 16'h0001, 16'h0000);
      else check("word", data_o, exp_q.pop_front());
    end
  end

  // ----------------------------------------
  // stimulus and expected block
  // ----------------------------------------
  task automatic fill_inputs(input logic card);
    int k;
    card_mode_i = card;
    {cylinders_i, sectors_per_track_i, cur_cylinders_i, cur_heads_i} = {$urandom, $urandom};
    {cur_sectors_per_track_i, capabilities_i, validity_i, dma_modes_i} = {$urandom, $urandom};
    {dma_min_cycle_i, dma_rec_cycle_i, pio_min_cycle_i, pio_iordy_cycle_i} = {$urandom, $urandom};
    {security_i, heads_i, multiple_max_i} = $urandom;
    {multiple_setting_i, pio_mode_i, adv_pio_i} = 24'($urandom);
    total_sectors_i = $urandom;
    cur_capacity_i = $urandom;
    lba_sectors_i = $urandom;
    k = $urandom_range(19, 0);
    for (int b = 0; b < 20; b++) serial_i[159-8*b -: 8] = b < k ? 8'h20 : 8'($urandom_range(90, 48));
    for (int b = 0; b < 8; b++) firmware_i[63-8*b -: 8] = 8'($urandom_range(90, 48));
    for (int b = 0; b < 40; b++) model_i[319-8*b -: 8] = b < 40 - k ? 8'($urandom_range(90, 65)) : 8'h20;
  endtask

  task automatic push_block();
    logic [15:0] w;
    for (int i = 0; i < 256; i++) begin
      w = 16'h0000;
      case (i)
        0: w = card_mode_i ? SIG : IDE;
        1: w = cylinders_i;
        3: w = {8'h00, heads_i};
        6: w = sectors_per_track_i;
        7: w = total_sectors_i[31:16];
        8: w = total_sectors_i[15:0];
        22: w = 16'h0004;
        47: w = {8'h00, multiple_max_i};
        49: w = {capabilities_i[15:8], 8'h00};
        51: w = {pio_mode_i, 8'h00};
        53: w = validity_i | 16'h0001;
        54: w = cur_cylinders_i;
        55: w = cur_heads_i;
        56: w = cur_sectors_per_track_i;
        57: w = cur_capacity_i[15:0];
        58: w = cur_capacity_i[31:16];
        59: w = {8'h01, multiple_setting_i};
        60: w = lba_sectors_i[15:0];
        61: w = lba_sectors_i[31:16];
        63: w = card_mode_i ? 16'h0000 : dma_modes_i;
        64: w = {8'h00, adv_pio_i};
        65: w = card_mode_i ? 16'h0000 : dma_min_cycle_i;
        66: w = card_mode_i ? 16'h0000 : dma_rec_cycle_i;
        67: w = pio_min_cycle_i;
        68: w = pio_iordy_cycle_i;
        128: w = security_i;
        default: ;
      endcase
      if (i >= 10 && i <= 19) w = serial_i[159-16*(i-10) -: 16];
      if (i >= 23 && i <= 26) w = firmware_i[63-16*(i-23) -: 16];
      if (i >= 27 && i <= 46) w = model_i[319-16*(i-27) -: 16];
      exp_q.push_back(w);
    end
  endtask

  // twist 1: stalled reader plus a start while busy; twist 2: reset mid-block
  task automatic run(input logic card, input logic [1:0] m, input int twist);
    int n;
    @(posedge clock_i);
    #2;
    fill_inputs(card);
    pace = m;
    push_block();
    start_i = 1'b1;
    @(posedge clock_i);
    #2;
    start_i = 1'b0;
    check("busy", {15'h0000, busy_o}, 16'h0001);
    repeat (2) @(posedge clock_i);
    #2;
    check("first valid", {15'h0000, data_valid_o}, 16'h0001);
    if (twist == 1) begin
      start_i = 1'b1;
      repeat (30) @(posedge clock_i);
      #2;
      start_i = 1'b0;
      check("busy while full", {15'h0000, busy_o}, 16'h0001);
      check("held head", data_o, exp_q[0]);
      pace = 2'd0;
    end
    if (twist == 2) begin
      repeat (20) @(posedge clock_i);
      #2;
      rstn_i = 1'b0;
      exp_q.delete();
      repeat (2) @(posedge clock_i);
      #2;
      check("reset busy", {15'h0000, busy_o}, 16'h0000);
      check("reset valid", {15'h0000, data_valid_o}, 16'h0000);
      check("reset data", data_o, 16'h0000);
      rstn_i = 1'b1;
    end
    n = 0;
    while ((busy_o !== 1'b0 || exp_q.size() != 0) && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    #2;
    check("block done", 16'(exp_q.size()), 16'h0000);
    repeat (3) @(posedge clock_i);
    #2;
    check("idle after block", {15'h0000, data_valid_o}, 16'h0000);
  endtask

  initial begin
    void'($urandom(32'h4673c0ec));
    rstn_i = 1'b0;
    start_i = 1'b0;
    pace = 2'd2;
    fill_inputs(1'b0);
    repeat (10) @(posedge clock_i);
    #2;
    rstn_i = 1'b1;
    run(1'b0, 2'd0, 0);
    run(1'b1, 2'd1, 0);
    run(1'b1, 2'd2, 1);
    run(1'b0, 2'd1, 2);
    run(1'b0, 2'd0, 0);
    report_and_stop();
  end
endmodule

`default_nettype wire
